// >>> dv/frame_host_model.sv
// Behavioural serial frame engine driving register accesses and frame events
`timescale 1ns/10ps
module frame_host_model
(
	input  wire logic                        ref_clk,
	output fault_summary_pkg::reg_access_s   reg_access,
	output logic                             frame_start,
	output fault_summary_pkg::frame_errors_s frame_errors
);
	initial
	begin
		reg_access = '0;
		frame_start = 1'b0;
		frame_errors = '0;
	end

	// One access per call; released fields show the inverse, never the old value
	task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata);
		@(negedge ref_clk);
		reg_access <= '{1'b1, wr, addr, wdata};
		@(negedge ref_clk);
		reg_access <= '{1'b0, ~wr, ~addr, ~wdata};
	endtask

	task automatic new_frame();
		@(negedge ref_clk);
		frame_start <= 1'b1;
		@(negedge ref_clk);
		frame_start <= 1'b0;
	endtask

	// Pulse of one or more faults inside the current frame
	task automatic error(input logic [2:0] err);
		@(negedge ref_clk);
		frame_errors <= err;
		@(negedge ref_clk);
		frame_errors <= '0;
	endtask
endmodule

// >>> dv/test_fault_summary_status.sv
// Self-checking bench for the upper status word
`timescale 1ns/10ps
module test_fault_summary_status;
	logic                                 ref_clk;
	logic                                 reset_seen_flag_low;
	fault_summary_pkg::reg_access_s       reg_access;
	fault_summary_pkg::summary_faults_s   summary_faults;
	logic                                 frame_start;
	fault_summary_pkg::frame_errors_s     frame_errors;
	logic [fault_summary_pkg::HI_W-1:0]   status_hi;
	int                                   fails;
	int                                   checks;

	fault_summary_status u_fault_summary_status
	(
		.ref_clk        (ref_clk),
		.reset_seen_flag_low         (reset_seen_flag_low),
		.reg_access     (reg_access),
		.summary_faults (summary_faults),
		.frame_start    (frame_start),
		.frame_errors   (frame_errors),
		.status_hi      (status_hi)
	);

	frame_host_model u_frame_host_model
	(
		.ref_clk      (ref_clk),
		.reg_access   (reg_access),
		.frame_start  (frame_start),
		.frame_errors (frame_errors)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic do_reset();
		@(negedge ref_clk);
		reset_seen_flag_low <= 1'b0;
		repeat (10) @(negedge ref_clk);
		reset_seen_flag_low <= 1'b1;
	endtask

	// Reset image, ignored writes and write-one restore of the reset flag
	task automatic test_reset_flag();
		check(status_hi, 9'h0FF);
		u_frame_host_model.access(1'b1, 8'h01, 16'h0000);
		check(status_hi, 9'h0FF);
		u_frame_host_model.access(1'b1, 8'h02, 16'h8000);
		check(status_hi, 9'h0FF);
		u_frame_host_model.access(1'b1, 8'h01, 16'h8000);
		check(status_hi, 9'h1FF);
		do_reset();
		check(status_hi, 9'h0FF);
		u_frame_host_model.access(1'b1, 8'h01, 16'h8000);
		u_frame_host_model.access(1'b1, 8'h01, 16'h8000);
		check(status_hi, 9'h1FF);
	endtask

	// Each sticky summary: set, refused restore, sticky after fault drops, restore
	task automatic test_summaries();
		logic [3:0]  sf;
		logic [15:0] wd;
		for (int i = 0; i < 4; i++)
		begin
			sf = 4'h8 >> i;
			wd = 16'h4000 >> i;
			@(negedge ref_clk);
			summary_faults <= sf;
			repeat (2) @(negedge ref_clk);
			check({1'b1, status_hi[7:4], 4'hF}, {1'b1, ~sf, 4'hF});
			u_frame_host_model.access(1'b1, 8'h01, wd);
			check(status_hi, {1'b1, ~sf, 4'hF});
			summary_faults <= '0;
			repeat (2) @(negedge ref_clk);
			check(status_hi, {1'b1, ~sf, 4'hF});
			u_frame_host_model.access(1'b1, 8'h01, 16'h0000);
			check(status_hi, {1'b1, ~sf, 4'hF});
			u_frame_host_model.access(1'b1, 8'h01, wd);
			check(status_hi, 9'h1FF);
		end
	endtask

	// Per-frame faults: low for one frame only; address FEh is not a fault
	task automatic test_frame_faults();
		logic [3:0] exp;
		for (int k = 0; k < 5; k++)
		begin
			exp = (k < 4) ? ~(4'h8 >> k) : 4'hF;
			u_frame_host_model.new_frame();
			if (k < 3)
				u_frame_host_model.error(3'h4 >> k);
			else
				u_frame_host_model.access(1'b0, (k == 3) ? 8'hFF : 8'hFE, 16'h0000);
			check(status_hi, 9'h1FF);
			u_frame_host_model.new_frame();
			check(status_hi, {5'h1F, exp});
			u_frame_host_model.access(1'b1, 8'h01, 16'h0780);
			check(status_hi, {5'h1F, exp});
			u_frame_host_model.new_frame();
			check(status_hi, 9'h1FF);
		end
	endtask

	initial
	begin
		reset_seen_flag_low = 1'b0;
		summary_faults = '0;
		fails = 0;
		checks = 0;
		do_reset();
		test_reset_flag();
		test_summaries();
		test_frame_faults();
		test_done();
	end
endmodule

// >>> src/fault_summary_pkg.sv
// Constants, carriers and decode helpers for the fault summary status word
package fault_summary_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned HI_W   = 9;

	// Register placement and reset image of the whole status word
	localparam logic [ADDR_W-1:0] STATUS_HI_ADDR = 8'h01;
	localparam logic [ADDR_W-1:0] BAD_ADDR_MIN   = 8'hFF;
	localparam logic [DATA_W-1:0] STATUS_RESET   = 16'h7FC8;

	// Bit positions inside the status word
	localparam int unsigned BIT_RESET_SEEN  = 15;
	localparam int unsigned BIT_POWER       = 14;
	localparam int unsigned BIT_CONVERTER   = 13;
	localparam int unsigned BIT_DIGITAL     = 12;
	localparam int unsigned BIT_OVERCURRENT = 11;
	localparam int unsigned BIT_CHECK       = 10;
	localparam int unsigned BIT_TIMEOUT     = 9;
	localparam int unsigned BIT_EDGE_COUNT  = 8;
	localparam int unsigned BIT_BAD_ADDR    = 7;
	localparam int unsigned SUMMARY_CNT     = 4;

	// Reset image of bits 15..7 only
	localparam logic [HI_W-1:0] STATUS_HI_RESET = STATUS_RESET[DATA_W-1:BIT_BAD_ADDR];

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_access_s;

	// Each field high while any unmasked flag of that source register is set
	typedef struct packed {
		logic power;
		logic converter;
		logic digital;
		logic overcurrent;
	} summary_faults_s;

	// One-cycle pulses from the serial frame engine
	typedef struct packed {
		logic check;
		logic timeout;
		logic edge_count;
	} frame_errors_s;

	function automatic logic is_status_write(input reg_access_s acc);
		is_status_write = acc.valid && acc.write && (acc.addr == STATUS_HI_ADDR);
	endfunction

	function automatic logic is_bad_address(input reg_access_s acc);
		is_bad_address = acc.valid && (acc.addr >= BAD_ADDR_MIN);
	endfunction

endpackage

// >>> src/fault_summary_status.sv
// Bits 15..7 of the top-level status word: sticky summaries and per-frame faults
//
// Function
// (RQ1) Reset flag reads 0 after reset, write-1 restores
// (RQ2) Supply summary low while unmasked supply fault
// (RQ3) Converter summary low while unmasked converter fault
// (RQ4) Digital summary low while unmasked digital fault
// (RQ5) Overcurrent summary low while unmasked comparator fault
// (RQ6) Check-error bit shows last frame's fault
// (RQ7) Timeout bit shows last frame's timeout
// (RQ8) Edge-count bit shows last frame's miscount
// (RQ9) Address FFh or above counts as bad access
// (RQ10) Bad-address bit low in following frame only
// (RQ11) Word at address 01h, resets to 7FC8h
// (RQ12) Zero writes and read-only bit writes ignored
`timescale 1ns/10ps
module fault_summary_status
(
	input  wire logic                                      ref_clk,
	input  wire logic                                      reset_seen_flag_low,
	input  wire fault_summary_pkg::reg_access_s            reg_access,
	input  wire fault_summary_pkg::summary_faults_s        summary_faults,
	input  wire logic                                      frame_start,
	input  wire fault_summary_pkg::frame_errors_s          frame_errors,
	output logic [fault_summary_pkg::HI_W-1:0]             status_hi
);

	logic                                          status_write;
	logic                                          bad_access;
	logic [fault_summary_pkg::SUMMARY_CNT-1:0]     summary_any;
	logic [fault_summary_pkg::SUMMARY_CNT-1:0]     summary_restore;
	logic [fault_summary_pkg::SUMMARY_CNT-1:0]     summary_low_q;

	logic reset_seen_flag_low_q;
	logic frame_check_error_low_q;
	logic frame_timeout_low_q;
	logic edge_count_error_low_q;
	logic bad_address_access_low_q;

	// Faults collected within the frame in progress
	logic check_pend_q;
	logic timeout_pend_q;
	logic edge_count_pend_q;
	logic bad_addr_pend_q;

	logic power_fault_summary_low;
	logic converter_fault_summary_low;
	logic logic_fault_summary_low;
	logic overcurrent_fault_summary_low;

	assign status_write = fault_summary_pkg::is_status_write(reg_access); // [RQ11]
	assign bad_access   = fault_summary_pkg::is_bad_address(reg_access);  // [RQ9]

	// Index 3..0 follows bit 14..11
	assign summary_any = {summary_faults.power, summary_faults.converter,
		summary_faults.digital, summary_faults.overcurrent};

	// Only ones in the write data restore; zeros leave the flags alone
	assign summary_restore = {4{status_write}} &
		reg_access.wdata[fault_summary_pkg::BIT_POWER:fault_summary_pkg::BIT_OVERCURRENT]; // [RQ12]

	genvar g;
	generate
		for (g = 0; g < fault_summary_pkg::SUMMARY_CNT; g = g + 1)
		begin : gen_summary
			summary_flag_cell u_cell
			(
				.ref_clk     (ref_clk),
				.reset_seen_flag_low      (reset_seen_flag_low),
				.fault_any   (summary_any[g]),
				.restore_req (summary_restore[g]),
				.flag_low_q  (summary_low_q[g])
			);
		end
	endgenerate

	assign power_fault_summary_low       = summary_low_q[3];
	assign converter_fault_summary_low   = summary_low_q[2];
	assign logic_fault_summary_low       = summary_low_q[1];
	assign overcurrent_fault_summary_low = summary_low_q[0];

	// Cleared by any reset; only a host write of one brings it back
	always_ff @(posedge ref_clk)
	begin
		if (!reset_seen_flag_low)
			reset_seen_flag_low_q <= fault_summary_pkg::STATUS_RESET[fault_summary_pkg::BIT_RESET_SEEN]; // [RQ1]
		else if (status_write && reg_access.wdata[fault_summary_pkg::BIT_RESET_SEEN])
			reset_seen_flag_low_q <= 1'b1; // [RQ1] [RQ12]
	end

	// Pending faults of the running frame; a pulse at frame_start still
	// belongs to the frame that is ending, so the pending set just restarts
	always_ff @(posedge ref_clk)
	begin
		if (!reset_seen_flag_low)
		begin
			check_pend_q      <= 1'b0;
			timeout_pend_q    <= 1'b0;
			edge_count_pend_q <= 1'b0;
			bad_addr_pend_q   <= 1'b0;
		end
		else if (frame_start)
		begin
			check_pend_q      <= 1'b0;
			timeout_pend_q    <= 1'b0;
			edge_count_pend_q <= 1'b0;
			bad_addr_pend_q   <= 1'b0;
		end
		else
		begin
			check_pend_q      <= check_pend_q | frame_errors.check;           // [RQ6]
			timeout_pend_q    <= timeout_pend_q | frame_errors.timeout;       // [RQ7]
			edge_count_pend_q <= edge_count_pend_q | frame_errors.edge_count; // [RQ8]
			bad_addr_pend_q   <= bad_addr_pend_q | bad_access;                // [RQ9]
		end
	end

	// Shown flags change only at a frame boundary or in reset; host writes never touch them
	always_ff @(posedge ref_clk)
	begin
		if (!reset_seen_flag_low)
		begin
			frame_check_error_low_q  <= 1'b1;
			frame_timeout_low_q      <= 1'b1;
			edge_count_error_low_q   <= 1'b1;
			bad_address_access_low_q <= 1'b1;
		end
		else if (frame_start)
		begin
			frame_check_error_low_q  <= !(check_pend_q | frame_errors.check);           // [RQ6]
			frame_timeout_low_q      <= !(timeout_pend_q | frame_errors.timeout);       // [RQ7]
			edge_count_error_low_q   <= !(edge_count_pend_q | frame_errors.edge_count); // [RQ8]
			bad_address_access_low_q <= !(bad_addr_pend_q | bad_access);                // [RQ10]
		end
	end

	assign status_hi = {reset_seen_flag_low_q, power_fault_summary_low,
		converter_fault_summary_low, logic_fault_summary_low,
		overcurrent_fault_summary_low, frame_check_error_low_q,
		frame_timeout_low_q, edge_count_error_low_q,
		bad_address_access_low_q}; // [RQ11]

	// Checks against the status word behaviour

	property p_reset_flag_after_reset;
		@(posedge ref_clk)
		$rose(reset_seen_flag_low) |-> !reset_seen_flag_low_q;
	endproperty
	a_reset_flag_after_reset: assert property (p_reset_flag_after_reset) // [RQ1]
		else $error("Reset flag not low after reset");

	property p_reset_image;
		@(posedge ref_clk)
		$rose(reset_seen_flag_low) |-> status_hi == fault_summary_pkg::STATUS_HI_RESET;
	endproperty
	a_reset_image: assert property (p_reset_image) // [RQ11]
		else $error("Status bits 15..7 differ from reset image");

	property p_reset_held_image;
		@(posedge ref_clk)
		!reset_seen_flag_low |=> status_hi == fault_summary_pkg::STATUS_HI_RESET;
	endproperty
	a_reset_held_image: assert property (p_reset_held_image) // [RQ1] [RQ11]
		else $error("Status bits 15..7 not at reset image during reset");

	property p_reset_flag_rises_on_write;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		$rose(reset_seen_flag_low_q) |->
			$past(status_write) && $past(reg_access.wdata[fault_summary_pkg::BIT_RESET_SEEN]);
	endproperty
	a_reset_flag_rises_on_write: assert property (p_reset_flag_rises_on_write) // [RQ1]
		else $error("Reset flag restored without a write of one");

	property p_reset_flag_write_one;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		status_write && reg_access.wdata[fault_summary_pkg::BIT_RESET_SEEN]
			|=> reset_seen_flag_low_q;
	endproperty
	a_reset_flag_write_one: assert property (p_reset_flag_write_one) // [RQ1]
		else $error("Write of one did not restore reset flag");

	property p_reset_flag_zero_write;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		!reset_seen_flag_low_q && !(status_write &&
			reg_access.wdata[fault_summary_pkg::BIT_RESET_SEEN]) |=> !reset_seen_flag_low_q;
	endproperty
	a_reset_flag_zero_write: assert property (p_reset_flag_zero_write) // [RQ12]
		else $error("Reset flag changed without a write of one");

	property p_power_summary;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		summary_faults.power ##1 summary_faults.power |-> !power_fault_summary_low;
	endproperty
	a_power_summary: assert property (p_power_summary) // [RQ2]
		else $error("Power summary high while a power fault stands");

	property p_converter_summary;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		summary_faults.converter ##1 summary_faults.converter |-> !converter_fault_summary_low;
	endproperty
	a_converter_summary: assert property (p_converter_summary) // [RQ3]
		else $error("Converter summary high while a converter fault stands");

	property p_digital_summary;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		summary_faults.digital ##1 summary_faults.digital |-> !logic_fault_summary_low;
	endproperty
	a_digital_summary: assert property (p_digital_summary) // [RQ4]
		else $error("Digital summary high while a digital fault stands");

	property p_overcurrent_summary;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		summary_faults.overcurrent ##1 summary_faults.overcurrent
			|-> !overcurrent_fault_summary_low;
	endproperty
	a_overcurrent_summary: assert property (p_overcurrent_summary) // [RQ5]
		else $error("Overcurrent summary high while a comparator fault stands");

	// Restore must work once the source is clear, not merely be allowed
	property p_power_restore;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		status_write && reg_access.wdata[fault_summary_pkg::BIT_POWER] &&
			!summary_faults.power |=> power_fault_summary_low;
	endproperty
	a_power_restore: assert property (p_power_restore) // [RQ2]
		else $error("Power summary not restored by a write of one");

	property p_overcurrent_restore;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		status_write && reg_access.wdata[fault_summary_pkg::BIT_OVERCURRENT] &&
			!summary_faults.overcurrent |=> overcurrent_fault_summary_low;
	endproperty
	a_overcurrent_restore: assert property (p_overcurrent_restore) // [RQ5]
		else $error("Overcurrent summary not restored by a write of one");

	property p_check_recorded;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_errors.check && !frame_start |=> check_pend_q;
	endproperty
	a_check_recorded: assert property (p_check_recorded) // [RQ6]
		else $error("Check error not held for the running frame");

	property p_edge_count_recorded;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_errors.edge_count && !frame_start |=> edge_count_pend_q;
	endproperty
	a_edge_count_recorded: assert property (p_edge_count_recorded) // [RQ8]
		else $error("Edge count error not held for the running frame");

	property p_frame_pend_restart;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_start |=> !(check_pend_q || timeout_pend_q ||
			edge_count_pend_q || bad_addr_pend_q);
	endproperty
	a_frame_pend_restart: assert property (p_frame_pend_restart) // [RQ6] [RQ7] [RQ8] [RQ10]
		else $error("Pending frame faults not restarted at frame start");

	property p_check_error_shown;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_start |=> frame_check_error_low_q ==
			!($past(check_pend_q) || $past(frame_errors.check));
	endproperty
	a_check_error_shown: assert property (p_check_error_shown) // [RQ6]
		else $error("Check error bit wrong after frame start");

	property p_timeout_recorded;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_errors.timeout && !frame_start |=> timeout_pend_q;
	endproperty
	a_timeout_recorded: assert property (p_timeout_recorded) // [RQ7]
		else $error("Timeout not held for the running frame");

	property p_timeout_next_frame;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_start && (timeout_pend_q || frame_errors.timeout) |=> !frame_timeout_low_q;
	endproperty
	a_timeout_next_frame: assert property (p_timeout_next_frame) // [RQ7]
		else $error("Timeout not shown in following frame");

	property p_edge_count_clean_frame;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_start && !edge_count_pend_q && !frame_errors.edge_count
			|=> edge_count_error_low_q;
	endproperty
	a_edge_count_clean_frame: assert property (p_edge_count_clean_frame) // [RQ8]
		else $error("Edge count bit not restored in clean frame");

	property p_bad_address_recorded;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		bad_access && !frame_start |=> bad_addr_pend_q;
	endproperty
	a_bad_address_recorded: assert property (p_bad_address_recorded) // [RQ9]
		else $error("Bad address access not held for the running frame");

	property p_bad_address_shown;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_start && (bad_addr_pend_q || bad_access) |=> !bad_address_access_low_q;
	endproperty
	a_bad_address_shown: assert property (p_bad_address_shown) // [RQ10]
		else $error("Bad address access not shown in next frame");

	property p_bad_address_clean_frame;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		frame_start && !bad_addr_pend_q && !bad_access |=> bad_address_access_low_q;
	endproperty
	a_bad_address_clean_frame: assert property (p_bad_address_clean_frame) // [RQ10]
		else $error("Bad address bit not restored in clean frame");

	property p_frame_bits_hold;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		!frame_start |=> $stable({frame_check_error_low_q, frame_timeout_low_q,
			edge_count_error_low_q, bad_address_access_low_q});
	endproperty
	a_frame_bits_hold: assert property (p_frame_bits_hold) // [RQ10] [RQ12]
		else $error("Per-frame bit changed inside a frame");

endmodule

// >>> src/summary_flag_cell.sv
// Sticky active-low summary flag with write-one-to-restore
`timescale 1ns/10ps
module summary_flag_cell
(
	input  wire logic ref_clk,
	input  wire logic reset_seen_flag_low,
	input  wire logic fault_any,
	input  wire logic restore_req,
	output logic      flag_low_q
);

	// Fault wins over a restore in the same cycle, so no event is lost
	always_ff @(posedge ref_clk)
	begin
		if (!reset_seen_flag_low)
			flag_low_q <= 1'b1;
		else if (fault_any)
			flag_low_q <= 1'b0; // [RQ2] [RQ3] [RQ4] [RQ5]
		else if (restore_req)
			flag_low_q <= 1'b1; // [RQ2] [RQ3] [RQ4] [RQ5]
	end

	property p_fault_drops_flag;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		fault_any |=> !flag_low_q;
	endproperty
	a_fault_drops_flag: assert property (p_fault_drops_flag) // [RQ2] [RQ3] [RQ4] [RQ5]
		else $error("Summary flag stayed high during a fault");

	property p_restore_needs_clear_and_write;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		$rose(flag_low_q) && $past(reset_seen_flag_low) |-> $past(restore_req) && !$past(fault_any);
	endproperty
	a_restore_needs_clear_and_write: assert property (p_restore_needs_clear_and_write) // [RQ12]
		else $error("Summary flag restored without a write or while faulted");

	property p_low_holds_without_write;
		@(posedge ref_clk) disable iff (!reset_seen_flag_low)
		!flag_low_q && !restore_req |=> !flag_low_q;
	endproperty
	a_low_holds_without_write: assert property (p_low_holds_without_write) // [RQ2] [RQ3]
		else $error("Summary flag left low state on its own");

endmodule
